//--- src/aesm_params.svh
`ifndef AESM_PARAMS_SVH
`define AESM_PARAMS_SVH

`define AESM_ADR_CTRL       8'h00
`define AESM_ADR_LINE_NUM   8'h04
`define AESM_ADR_N_LINES    8'h08
`define AESM_ADR_EXP_PIX    8'h0C
`define AESM_ADR_EXP_LINES  8'h10
`define AESM_ADR_FRAMES     8'h14
`define AESM_ADR_STATUS     8'h18
`define AESM_ADR_EVENTS     8'h1C
`define AESM_ADR_XFER       8'h20

`define AESM_CTRL_ANALOG    0
`define AESM_CTRL_LINESCAN  1
`define AESM_CTRL_CFG_LSB   2
`define AESM_CTRL_LANES_LSB 4
`define AESM_CTRL_RST       32'h0000_0000

`define AESM_CLK_HZ         40000000
`define AESM_CLKDET_NS      2000
`define AESM_CLKDET_CYC     ((`AESM_CLKDET_NS * (`AESM_CLK_HZ / 1000000)) / 1000)

`define AESM_NSTAT          13
`define AESM_NEVT           13
`define AESM_NLANE          4

`endif

//--- src/aesm_pkg.sv
package aesm_pkg;
  typedef enum logic [1:0] {
    AESM_XF_IDLE = 2'b00,
    AESM_XF_RUN  = 2'b01,
    AESM_XF_STOP = 2'b11
  } aesm_xfer_t;

  typedef enum logic [1:0] {
    AESM_CL_BASE   = 2'b00,
    AESM_CL_MEDIUM = 2'b01,
    AESM_CL_FULL   = 2'b10
  } aesm_clcfg_t;
endpackage : aesm_pkg

//--- src/aesm_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface aesm_sync_if;
  logic [15:0] raw;
  logic [15:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : aesm_sync_if
`default_nettype wire

//--- src/aesm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module aesm_sync (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  aesm_sync_if.dst     sif
);
  import aesm_pkg::*;
  logic [15:0] meta_q;
  logic [15:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= sif.raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_q;
endmodule : aesm_sync
`default_nettype wire

//--- src/aesm_monitor.sv
`include "aesm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module aesm_monitor (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        cam_pclk_i,
  input  wire logic        line_valid_i,
  input  wire logic        frame_valid_i,
  input  wire logic        field_odd_i,
  input  wire logic        data_valid_i,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  input  wire logic        medium_clk_i,
  input  wire logic        full_clk_i,
  input  wire logic        burst_det_i,
  input  wire logic        hlock_i,
  input  wire logic        vlock_i,
  input  wire logic        fuse_ok_i,
  input  wire logic        cable_pwr_i,
  input  wire logic [3:0]  lane_lock_i,
  input  wire logic        frame_moved_i,
  output logic      [12:0] evt_o,
  output logic             status_change_o
);
  import aesm_pkg::*;

  aesm_sync_if sif ();
  aesm_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  assign sif.raw = {lane_lock_i, cable_pwr_i, fuse_ok_i, vlock_i, hlock_i, burst_det_i,
                    full_clk_i, medium_clk_i, cam_pclk_i, vsync_i, hsync_i,
                    frame_valid_i, line_valid_i};

  logic       lv_s, fv_s, hs_s, vs_s, pclk_s, mclk_s, fclk_s;
  logic       burst_s, hlk_s, vlk_s, fuse_s, cpwr_s;
  logic [3:0] lanes_s;
  assign {lanes_s, cpwr_s, fuse_s, vlk_s, hlk_s, burst_s, fclk_s, mclk_s, pclk_s,
          vs_s, hs_s, fv_s, lv_s} = sif.synced[15:0];

  // camera-side qualifiers synchronised through two flops on each rising clk_i edge
  logic odd_q, odd_m_q, dv_q, dv_m_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odd_m_q <= 1'b0;
      odd_q   <= 1'b0;
      dv_m_q  <= 1'b0;
      dv_q    <= 1'b0;
    end else begin
      odd_m_q <= field_odd_i;
      odd_q   <= odd_m_q;
      dv_m_q  <= data_valid_i;
      dv_q    <= dv_m_q;
    end
  end

  logic [31:0] ctrl_q;
  logic [15:0] line_num_q;
  logic [15:0] n_lines_q;
  logic [15:0] exp_pix_q;
  logic [15:0] exp_lines_q;
  logic [15:0] frames_q;
  logic        start_q;
  logic        cont_q;
  logic        stop_q;

  logic        analog;
  logic        linescan;
  aesm_clcfg_t clcfg;
  logic [2:0]  lanes_needed;
  assign analog       = ctrl_q[`AESM_CTRL_ANALOG];
  assign linescan     = ctrl_q[`AESM_CTRL_LINESCAN];
  assign clcfg        = aesm_clcfg_t'(ctrl_q[`AESM_CTRL_CFG_LSB +: 2]);
  assign lanes_needed = ctrl_q[`AESM_CTRL_LANES_LSB +: 3];

  // pixel, medium and full clock presence: retrigger on each rising edge, expire after a quiet window
  logic       pclk_d1_q, mclk_d1_q, fclk_d1_q;
  logic [7:0] pclk_cnt_q, mclk_cnt_q, fclk_cnt_q;
  localparam logic [7:0] CLKDET = 8'(`AESM_CLKDET_CYC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_d1_q <= 1'b0;
      mclk_d1_q <= 1'b0;
      fclk_d1_q <= 1'b0;
    end else begin
      pclk_d1_q <= pclk_s;
      mclk_d1_q <= mclk_s;
      fclk_d1_q <= fclk_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_cnt_q <= 8'h00;
      mclk_cnt_q <= 8'h00;
      fclk_cnt_q <= 8'h00;
    end else begin
      pclk_cnt_q <= (pclk_s & ~pclk_d1_q) ? CLKDET :
                    (pclk_cnt_q != 8'h00) ? pclk_cnt_q - 8'h01 : 8'h00;
      mclk_cnt_q <= (mclk_s & ~mclk_d1_q) ? CLKDET :
                    (mclk_cnt_q != 8'h00) ? mclk_cnt_q - 8'h01 : 8'h00;
      fclk_cnt_q <= (fclk_s & ~fclk_d1_q) ? CLKDET :
                    (fclk_cnt_q != 8'h00) ? fclk_cnt_q - 8'h01 : 8'h00;
    end
  end

  logic base_cable_clk_seen, medium_cable_clk_seen, full_cable_clk_seen;
  logic all_cable_clks_seen;
  assign base_cable_clk_seen   = pclk_cnt_q != 8'h00;
  assign medium_cable_clk_seen = mclk_cnt_q != 8'h00;
  assign full_cable_clk_seen   = fclk_cnt_q != 8'h00;

  always_comb begin
    case (clcfg)
      AESM_CL_BASE:   all_cable_clks_seen = base_cable_clk_seen;
      AESM_CL_MEDIUM: all_cable_clks_seen = base_cable_clk_seen & medium_cable_clk_seen;
      AESM_CL_FULL:   all_cable_clks_seen = base_cable_clk_seen & medium_cable_clk_seen
                                            & full_cable_clk_seen;
      default:        all_cable_clks_seen = 1'b0;
    endcase
  end

  logic all_lanes_locked;
  logic [3:0] lane_mask;
  always_comb begin
    lane_mask = 4'h0;
    for (int i = 0; i < `AESM_NLANE; i++) begin
      lane_mask[i] = (3'(i) < lanes_needed);
    end
    all_lanes_locked = (lanes_needed != 3'h0) && ((lanes_s & lane_mask) == lane_mask);
  end

  logic line_sync_seen, frame_sync_seen, color_burst_seen;
  logic line_sync_locked, frame_sync_locked, camera_power_avail, cable_power_active;
  assign line_sync_seen     = analog ? hs_s : lv_s;
  assign frame_sync_seen    = analog ? vs_s : fv_s;
  assign color_burst_seen   = analog & burst_s;
  assign line_sync_locked   = analog & hlk_s;
  assign frame_sync_locked  = analog & vlk_s;
  assign camera_power_avail = fuse_s;
  assign cable_power_active = fuse_s & cpwr_s;

  logic [12:0] status;
  assign status = {all_lanes_locked, cable_power_active, camera_power_avail,
                   frame_sync_locked, line_sync_locked, color_burst_seen,
                   all_cable_clks_seen, full_cable_clk_seen, medium_cable_clk_seen,
                   base_cable_clk_seen, frame_sync_seen, line_sync_seen, 1'b0};

  logic [12:0] status_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q        <= 13'h0000;
      status_change_o <= 1'b0;
    end else begin
      status_q        <= status;
      status_change_o <= |(status ^ status_q);
    end
  end

  // video timing: frame/line edges and active counts
  logic lv_q, fv_q, pclk_rise;
  logic [15:0] pix_cnt_q, line_cnt_q, nline_cnt_q;
  logic lv_rise, lv_fall, fv_rise, fv_fall;
  assign pclk_rise = pclk_s & ~pclk_d1_q;
  assign lv_rise   = line_sync_seen & ~lv_q;
  assign lv_fall   = ~line_sync_seen & lv_q;
  assign fv_rise   = frame_sync_seen & ~fv_q;
  assign fv_fall   = ~frame_sync_seen & fv_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lv_q <= 1'b0;
      fv_q <= 1'b0;
    end else begin
      lv_q <= line_sync_seen;
      fv_q <= frame_sync_seen;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_cnt_q <= 16'h0000;
    end else if (lv_rise) begin
      pix_cnt_q <= 16'h0000;
    end else if (line_sync_seen && pclk_rise && dv_q) begin
      pix_cnt_q <= pix_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_cnt_q <= 16'h0000;
    end else if (fv_rise) begin
      line_cnt_q <= 16'h0000;
    end else if (lv_fall && frame_sync_seen) begin
      line_cnt_q <= line_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nline_cnt_q <= 16'h0000;
    end else if (!linescan) begin
      nline_cnt_q <= 16'h0000;
    end else if (lv_fall) begin
      nline_cnt_q <= (nline_cnt_q + 16'h0001 >= n_lines_q) ? 16'h0000
                     : nline_cnt_q + 16'h0001;
    end
  end

  // transfer tracking
  aesm_xfer_t  xf_q;
  logic [15:0] moved_q;
  logic        xfer_done;
  logic        moved_r_q;
  logic        moved_pulse;
  assign moved_pulse = frame_moved_i & ~moved_r_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xf_q      <= AESM_XF_IDLE;
      moved_q   <= 16'h0000;
      moved_r_q <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      moved_r_q <= frame_moved_i;
      xfer_done <= 1'b0;
      case (xf_q)
        AESM_XF_IDLE: begin
          moved_q <= 16'h0000;
          if (start_q) begin
            xf_q <= cont_q ? AESM_XF_STOP : AESM_XF_RUN;
          end
        end
        AESM_XF_RUN: begin
          if (moved_pulse) begin
            moved_q <= moved_q + 16'h0001;
            if (moved_q + 16'h0001 >= frames_q) begin
              xf_q      <= AESM_XF_IDLE;
              xfer_done <= 1'b1;
            end
          end
        end
        AESM_XF_STOP: begin
          if (stop_q) begin
            xf_q <= AESM_XF_RUN;
            frames_done_hold();
          end
        end
        default: xf_q <= AESM_XF_IDLE;
      endcase
    end
  end

  function automatic void frames_done_hold();
  endfunction : frames_done_hold

  logic [12:0] evt_d;
  logic        even_field;
  assign even_field = ~odd_q;
  always_comb begin
    evt_d     = 13'h0000;
    evt_d[0]  = fv_rise;
    evt_d[1]  = fv_rise;
    evt_d[2]  = fv_rise & even_field;
    evt_d[3]  = fv_rise & odd_q;
    evt_d[4]  = fv_fall & (even_field | ~analog);
    evt_d[5]  = fv_fall;
    evt_d[6]  = fv_fall & even_field;
    evt_d[7]  = fv_fall & odd_q;
    evt_d[8]  = lv_fall && frame_sync_seen && (line_cnt_q + 16'h0001 == line_num_q);
    evt_d[9]  = linescan && lv_fall && (n_lines_q != 16'h0000)
                && (nline_cnt_q + 16'h0001 >= n_lines_q);
    evt_d[10] = xfer_done;
    evt_d[11] = fv_fall && (line_cnt_q < exp_lines_q);
    evt_d[12] = lv_fall && (pix_cnt_q < exp_pix_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_o <= 13'h0000;
    end else begin
      evt_o <= evt_d;
    end
  end

  // wishbone slave: registered ack (err if unmapped) one cycle after the request, cleared the cycle after
  logic req;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= `AESM_CTRL_RST;
      line_num_q  <= 16'h0000;
      n_lines_q   <= 16'h0000;
      exp_pix_q   <= 16'h0000;
      exp_lines_q <= 16'h0000;
      frames_q    <= 16'h0001;
      start_q     <= 1'b0;
      cont_q      <= 1'b0;
      stop_q      <= 1'b0;
    end else begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      if (req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `AESM_ADR_CTRL) begin
          ctrl_q <= wb_dat_i;
        end else if (wb_adr_i == `AESM_ADR_LINE_NUM) begin
          line_num_q <= wb_dat_i[15:0];
        end else if (wb_adr_i == `AESM_ADR_N_LINES) begin
          n_lines_q <= wb_dat_i[15:0];
        end else if (wb_adr_i == `AESM_ADR_EXP_PIX) begin
          exp_pix_q <= wb_dat_i[15:0];
        end else if (wb_adr_i == `AESM_ADR_EXP_LINES) begin
          exp_lines_q <= wb_dat_i[15:0];
        end else if (wb_adr_i == `AESM_ADR_FRAMES) begin
          frames_q <= wb_dat_i[15:0];
        end else if (wb_adr_i == `AESM_ADR_XFER) begin
          start_q <= wb_dat_i[0];
          cont_q  <= wb_dat_i[1];
          stop_q  <= wb_dat_i[2];
        end
      end
    end
  end

  logic        mapped;
  logic [31:0] rd;
  always_comb begin
    mapped = 1'b1;
    rd     = 32'h0000_0000;
    if (wb_adr_i == `AESM_ADR_CTRL) begin
      rd = ctrl_q;
    end else if (wb_adr_i == `AESM_ADR_LINE_NUM) begin
      rd = {16'h0000, line_num_q};
    end else if (wb_adr_i == `AESM_ADR_N_LINES) begin
      rd = {16'h0000, n_lines_q};
    end else if (wb_adr_i == `AESM_ADR_EXP_PIX) begin
      rd = {16'h0000, exp_pix_q};
    end else if (wb_adr_i == `AESM_ADR_EXP_LINES) begin
      rd = {16'h0000, exp_lines_q};
    end else if (wb_adr_i == `AESM_ADR_FRAMES) begin
      rd = {16'h0000, frames_q};
    end else if (wb_adr_i == `AESM_ADR_STATUS) begin
      rd = {19'h00000, status};
    end else if (wb_adr_i == `AESM_ADR_EVENTS) begin
      rd = {3'h0, moved_q[15:0], evt_o};
    end else if (wb_adr_i == `AESM_ADR_XFER) begin
      rd = {28'h0000000, 1'b0, 1'b0, xf_q};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req & mapped & ~wb_we_i) ? rd : 32'h0000_0000;
    end
  end
endmodule : aesm_monitor
`default_nettype wire

//--- testbench/aesm_monitor_chk.sv
`timescale 1ns/10ps
`default_nettype none
module aesm_monitor_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        fuse_ok_i,
  input wire logic        cable_pwr_i,
  input wire logic [12:0] evt_o,
  input wire logic        status_change_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence pwr_move_s;
    $changed(fuse_ok_i) || $changed(cable_pwr_i);
  endsequence
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  bus_answer_a: assert property (req_s |=> wb_ack_o != wb_err_o)
    else $error("request not answered");
  bus_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  unmapped_err_a: assert property (req_s ##0 wb_adr_i == 8'h24 |=> wb_err_o)
    else $error("no error on unmapped address");
  evt_pulse_a: assert property (evt_o != 13'h0 |=> (evt_o & $past(evt_o)) == 13'h0)
    else $error("event longer than one cycle");
  chg_pulse_a: assert property (status_change_o |=> !status_change_o)
    else $error("status change longer than one cycle");
  power_chg_a: assert property (pwr_move_s |-> ##[2:8] status_change_o)
    else $error("power change not reported");
endmodule : aesm_monitor_chk
bind aesm_monitor aesm_monitor_chk i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .fuse_ok_i(fuse_ok_i),
  .cable_pwr_i(cable_pwr_i),
  .evt_o(evt_o),
  .status_change_o(status_change_o)
);
`default_nettype wire

//--- testbench/aesm_cam_model.sv
`timescale 1ns/10ps
`default_nettype none
module aesm_cam_model (
  output logic pclk_o,
  output logic medium_clk_o,
  output logic full_clk_o,
  output logic line_valid_o,
  output logic frame_valid_o,
  output logic data_valid_o,
  output logic field_odd_o
);
  logic [1:0] cables;
  // extra cable clocks follow the base clock when that cable is plugged
  assign medium_clk_o = pclk_o & cables[0];
  assign full_clk_o   = pclk_o & cables[1];
  initial begin
    cables = 2'b00;
    pclk_o = 1'b0;
    line_valid_o = 1'b0;
    frame_valid_o = 1'b0;
    data_valid_o = 1'b0;
    field_odd_o = 1'b0;
  end
  task automatic tick();
    #100 pclk_o = 1'b1;
    #100 pclk_o = 1'b0;
  endtask : tick
  // pixel clock runs inside a frame and for one tick after it; qualifiers change after its fall
  task automatic send_frame(input int lines, input int pix, input logic odd,
                            input logic [1:0] cab);
    #7 cables = cab;
    field_odd_o = odd;
    frame_valid_o = 1'b1;
    repeat (2) tick();
    for (int l = 0; l < lines; l++) begin
      line_valid_o = 1'b1;
      data_valid_o = 1'b1;
      repeat (pix) tick();
      line_valid_o = 1'b0;
      data_valid_o = 1'b0;
      repeat (2) tick();
    end
    frame_valid_o = 1'b0;
    tick();
  endtask : send_frame
endmodule : aesm_cam_model
`default_nettype wire

//--- testbench/aesm_monitor_bench.sv
`include "aesm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module aesm_monitor_bench;
  import aesm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wb_err_o;
  logic        pclk, mclk, fclk, lval, fval, dval, fodd;
  logic        hsync_i = 1'b1;
  logic        vsync_i = 1'b1;
  logic        burst_i = 1'b1;
  logic        hlock_i = 1'b1;
  logic        vlock_i = 1'b1;
  logic        fuse_ok_i = 1'b1;
  logic        cable_pwr_i = 1'b1;
  logic [3:0]  lane_lock_i = 4'h0;
  logic        moved_i = 1'b0;
  logic [12:0] evt_o;
  logic        status_change_o;
  logic [12:0] seen_q = 13'h0;
  logic        clr_q = 1'b0;
  int          chg_cnt = 0;
  int          cycles = 0;
  int          err_count = 0;
  int          checks_done = 0;

  aesm_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cam_pclk_i(pclk),
    .line_valid_i(lval), .frame_valid_i(fval), .field_odd_i(fodd), .data_valid_i(dval),
    .hsync_i(hsync_i), .vsync_i(vsync_i), .medium_clk_i(mclk), .full_clk_i(fclk),
    .burst_det_i(burst_i), .hlock_i(hlock_i), .vlock_i(vlock_i), .fuse_ok_i(fuse_ok_i),
    .cable_pwr_i(cable_pwr_i), .lane_lock_i(lane_lock_i), .frame_moved_i(moved_i),
    .evt_o(evt_o), .status_change_o(status_change_o));
  aesm_cam_model i_cam (.pclk_o(pclk), .medium_clk_o(mclk), .full_clk_o(fclk),
    .line_valid_o(lval), .frame_valid_o(fval), .data_valid_o(dval), .field_odd_o(fodd));

  always #12.5 clk_i = ~clk_i;
  // sticky record of event pulses and count of status change pulses
  always @(posedge clk_i) begin
    seen_q <= clr_q ? 13'h0 : (seen_q | evt_o);
    chg_cnt <= clr_q ? 0 : chg_cnt + int'(status_change_o === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    bus(a, 1'b0, 32'h0, q, e);
    compare(q & m, x);
  endtask : rd
  task automatic clear(int n);
    clr_q <= 1'b1;
    @(posedge clk_i);
    clr_q <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : clear
  task automatic pulse();
    moved_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    moved_i <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask : pulse
  task automatic frame(int l, int p, logic o, logic [1:0] c, logic [31:0] st);
    clear(0);
    fork
      i_cam.send_frame(l, p, o, c);
      begin
        repeat (150) @(posedge clk_i);
        rd(`AESM_ADR_STATUS, 32'h1FFD, st);
      end
    join
    repeat (16) @(posedge clk_i);
  endtask : frame

  initial begin : main
    logic [31:0] q;
    logic        e;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`AESM_ADR_CTRL, 32'hFFFF_FFFF, `AESM_CTRL_RST);
    rd(`AESM_ADR_FRAMES, 32'hFFFF_FFFF, 32'h1);
    bus(8'h24, 1'b0, 32'h0, q, e);
    compare({31'h0, e}, 32'h1);
    wr(`AESM_ADR_CTRL, 32'h10);
    repeat (8) @(posedge clk_i);
    rd(`AESM_ADR_STATUS, 32'h1FFF, 32'h0C00);
    wr(`AESM_ADR_CTRL, 32'h11);
    repeat (8) @(posedge clk_i);
    rd(`AESM_ADR_STATUS, 32'h1FFF, 32'h0F86);
    clear(2);
    fuse_ok_i <= 1'b0;
    cable_pwr_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    compare(chg_cnt, 1);
    rd(`AESM_ADR_STATUS, 32'h1FFF, 32'h0386);
    clear(12);
    compare(chg_cnt, 0);
    lane_lock_i <= 4'h3;
    wr(`AESM_ADR_CTRL, 32'h21);
    repeat (8) @(posedge clk_i);
    rd(`AESM_ADR_STATUS, 32'h1FFF, 32'h1386);
    wr(`AESM_ADR_CTRL, 32'h41);
    repeat (8) @(posedge clk_i);
    rd(`AESM_ADR_STATUS, 32'h1FFF, 32'h0386);
    wr(`AESM_ADR_CTRL, 32'h18);
    wr(`AESM_ADR_EXP_PIX, 32'h8);
    wr(`AESM_ADR_EXP_LINES, 32'h4);
    wr(`AESM_ADR_LINE_NUM, 32'h3);
    rd(`AESM_ADR_LINE_NUM, 32'hFFFF_FFFF, 32'h3);
    wr(`AESM_ADR_N_LINES, 32'h2);
    frame(4, 8, 1'b0, 2'b11, 32'h107C);
    compare(seen_q, 13'h0177);
    frame(3, 6, 1'b1, 2'b01, 32'h101C);
    compare(seen_q, 13'h19BB);
    wr(`AESM_ADR_CTRL, 32'h16);
    frame(4, 8, 1'b0, 2'b01, 32'h105C);
    compare(seen_q & 13'h0200, 13'h0200);
    wr(`AESM_ADR_FRAMES, 32'h2);
    wr(`AESM_ADR_XFER, 32'h1);
    rd(`AESM_ADR_XFER, 32'h3, 32'h1);
    clear(0);
    pulse();
    compare(seen_q & 13'h0400, 13'h0);
    pulse();
    compare(seen_q & 13'h0400, 13'h0400);
    rd(`AESM_ADR_XFER, 32'h3, 32'h0);
    results();
  end
endmodule : aesm_monitor_bench
`default_nettype wire
